// ### include/bwic_pkg.sv
package bwic_pkg;

    // register map of the plain register port
    localparam logic [3:0] IDLE_CTRL_OFS = 4'h0;
    localparam logic [3:0] WAIT_CTRL_OFS = 4'h4;
    localparam logic [15:0] IDLE_CTRL_RST = 16'h3ff3;
    localparam logic [15:0] WAIT_CTRL_RST = 16'hffff;
    // reserved bits 14, 3 and 2 are never stored
    localparam logic [15:0] IDLE_CTRL_WMASK = 16'hbff3;
    localparam int SAMPLE_SEL_BIT = 15;
    localparam int A6_WAIT_LSB = 13;
    localparam int A5_WAIT_LSB = 10;
    localparam int A4_WAIT_LSB = 7;
    localparam int A3_WAIT_LSB = 5;
    localparam int A2_WAIT_LSB = 3;
    localparam int A0_WAIT_LSB = 0;
    localparam int NUM_PINS = 2;
    localparam int PIN_BUSCLK = 0;
    localparam int PIN_WAIT = 1;
    localparam logic [3:0] ONE_STATE = 4'h1;

    // a bus request: area, direction, burst transfers after the first
    typedef struct packed {
        logic [2:0] area;
        logic write;
        logic [3:0] beats;
    } bwic_req_t;

    // external bus cycle status
    typedef struct packed {
        logic active;
        logic idle;
        logic [2:0] area;
        logic write;
    } bwic_bus_t;

    function automatic logic [3:0] idle_states(input logic [15:0] r, input logic [2:0] area);
        logic [1:0] f;
        f = 2'b00;
        if (area != 3'h1 && area != 3'h7) begin
            f = r[{area, 1'b0} +: 2];
        end
        case (f)
            2'b10: return 4'h2;
            2'b11: return 4'h3;
            default: return 4'h1;
        endcase
    endfunction

    function automatic logic [2:0] wait_code(input logic [15:0] r, input logic [2:0] area);
        case (area)
            3'h6: return r[A6_WAIT_LSB +: 3];
            3'h5: return r[A5_WAIT_LSB +: 3];
            3'h4: return r[A4_WAIT_LSB +: 3];
            3'h3: return {1'b0, r[A3_WAIT_LSB +: 2]};
            3'h2: return {1'b0, r[A2_WAIT_LSB +: 2]};
            3'h0: return r[A0_WAIT_LSB +: 3];
            default: return 3'h0;
        endcase
    endfunction

    function automatic logic [3:0] first_waits(input logic [2:0] code);
        case (code)
            3'h5: return 4'h6;
            3'h6: return 4'h8;
            3'h7: return 4'ha;
            default: return {1'b0, code};
        endcase
    endfunction

    function automatic logic [3:0] burst_pitch(input logic [2:0] code);
        case (code)
            3'h0: return 4'h2;
            3'h1: return 4'h2;
            3'h2: return 4'h3;
            3'h3: return 4'h4;
            3'h4: return 4'h4;
            3'h5: return 4'h6;
            3'h6: return 4'h8;
            default: return 4'ha;
        endcase
    endfunction

endpackage

// ### rtl/bwic_pin_sync.sv
`timescale 1ns/1ps
module bwic_pin_sync #(
    parameter logic RST_LEVEL = 1'b1
) (
    // clock and reset
    input logic clk,
    input logic rst,
    // asynchronous pin
    input logic pin,
    // filtered level and its edges
    output logic level,
    output logic rise,
    output logic fall
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic agree;

    // s1 feeds only s2; a change counts once s2 and s3 agree
    assign agree = (s2_reg == s3_reg);

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_reg <= RST_LEVEL;
            s2_reg <= RST_LEVEL;
            s3_reg <= RST_LEVEL;
        end else begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            level <= RST_LEVEL;
            rise <= 1'b0;
            fall <= 1'b0;
        end else begin
            rise <= agree && s3_reg && !level;
            fall <= agree && !s3_reg && level;
            if (agree) begin
                level <= s3_reg;
            end
        end
    end
endmodule

// ### rtl/bwic_bus_timing.sv
`timescale 1ns/1ps
// Summary of operation
// - idle states go between cycles on area change or read then write.
// - idle code 00/01 gives one, 10 two, 11 three; reset is 11.
// - area n idle field sits at bits 2n+1:2n; areas 6,5,4,3,2,0 only.
// - sample-edge bit 15 set samples wait on falling bus clock edge.
// - idle control loads 0x3ff3 on power-on; manual reset, standby keep it.
// - wait control loads 0xffff on power-on; manual reset, standby keep it.
// - idle control bits 14, 3, 2 read zero; software writes zero there.
// - areas 6,5 codes give 0,1,2,3,4,6,8,10 waits; code 0 ignores wait.
// - burst transfers after first take 2,2,3,4,4,6,8,10 states, wait enabled.
// - area 4 code gives 0,1,2,3,4,6,8,10 waits; code 0 ignores wait.
// - area 3 two-bit code gives 0..3 waits; code 0 ignores wait.
// - wait control fields: 6 at 15:13, 5 12:10, 4 9:7, 3 6:5, 2 4:3, 0 2:0.
// - area 2 two-bit code gives 0..3 waits; code 0 ignores; resets to 11.
// - area 0 code uses the area 6/5 first waits and burst pitch.
module bwic_bus_timing (
    // clock and power-on reset
    input logic clk,
    input logic rst,
    // manual reset and standby: sequencer only
    input logic manualRst,
    input logic standby,
    // register port
    input logic [3:0] regAddr,
    input logic [15:0] regWdata,
    input logic regWr,
    input logic regRd,
    output logic [15:0] regRdata,
    // bus requests
    input logic reqValid,
    input bwic_pkg::bwic_req_t req,
    output logic reqReady,
    // external pins
    input logic busClockIn,
    input logic waitN,
    // bus cycle progress
    output bwic_pkg::bwic_bus_t bus,
    output logic beatDone,
    output logic cycleDone
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_GAP = 2'b01,
        ST_FIRST = 2'b10,
        ST_BURST = 2'b11
    } bwic_state_t;

    bwic_state_t state_reg;
    logic [15:0] idleCtrl_reg;
    logic [15:0] waitCtrl_reg;
    logic [3:0] cnt_reg;
    logic [3:0] beats_reg;
    logic phaseWaitEn_reg;
    logic [2:0] lastArea_reg;
    logic lastRead_reg;
    logic lastValid_reg;
    logic waitHeld_reg;
    logic [2:0] curCode_reg;
    logic [bwic_pkg::NUM_PINS-1:0] pins;
    logic [bwic_pkg::NUM_PINS-1:0] pinLevel;
    logic [bwic_pkg::NUM_PINS-1:0] pinRise;
    logic [bwic_pkg::NUM_PINS-1:0] pinFall;
    logic busRise;
    logic sampleEvent;
    logic accept;
    logic gapNeed;
    logic phaseEnd;
    logic [2:0] reqCode;
    logic sampleSel;

    assign pins[bwic_pkg::PIN_BUSCLK] = busClockIn;
    assign pins[bwic_pkg::PIN_WAIT] = waitN;

    genvar gi;
    generate
        for (gi = 0; gi < bwic_pkg::NUM_PINS; gi++) begin : g_sync
            bwic_pin_sync #(
                .RST_LEVEL(1'b1)
            ) u_sync (
                .clk(clk),
                .rst(rst),
                .pin(pins[gi]),
                .level(pinLevel[gi]),
                .rise(pinRise[gi]),
                .fall(pinFall[gi])
            );
        end
    endgenerate

    // one bus state per rising edge of the bus clock
    assign busRise = pinRise[bwic_pkg::PIN_BUSCLK];
    assign sampleSel = idleCtrl_reg[bwic_pkg::SAMPLE_SEL_BIT];
    // with the select bit clear wait is taken on the rising edge; memory must not use it then
    assign sampleEvent = sampleSel ? pinFall[bwic_pkg::PIN_BUSCLK] : busRise;

    // registers: only power-on reset touches them
    always_ff @(posedge clk) begin
        if (rst) begin
            idleCtrl_reg <= bwic_pkg::IDLE_CTRL_RST;
            waitCtrl_reg <= bwic_pkg::WAIT_CTRL_RST;
        end else if (regWr) begin
            if (regAddr == bwic_pkg::IDLE_CTRL_OFS) begin
                idleCtrl_reg <= regWdata & bwic_pkg::IDLE_CTRL_WMASK;
            end
            if (regAddr == bwic_pkg::WAIT_CTRL_OFS) begin
                waitCtrl_reg <= regWdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            regRdata <= 16'h0000;
        end else if (regRd) begin
            case (regAddr)
                bwic_pkg::IDLE_CTRL_OFS: regRdata <= idleCtrl_reg;
                bwic_pkg::WAIT_CTRL_OFS: regRdata <= waitCtrl_reg;
                default: regRdata <= 16'h0000;
            endcase
        end
    end

    // wait pin latched only at the selected bus clock edge
    always_ff @(posedge clk) begin
        if (rst) begin
            waitHeld_reg <= 1'b0;
        end else if (sampleEvent) begin
            waitHeld_reg <= !pinLevel[bwic_pkg::PIN_WAIT];
        end
    end

    assign reqReady = (state_reg == ST_IDLE) && !standby && !manualRst;
    assign accept = reqValid && reqReady;
    assign reqCode = bwic_pkg::wait_code(waitCtrl_reg, req.area);
    // turnaround on area change, or a write after a read in the same area
    assign gapNeed = lastValid_reg && ((req.area != lastArea_reg) || (lastRead_reg && req.write));
    // a state ends on a bus edge unless wait stretches it
    assign phaseEnd = busRise && (cnt_reg == bwic_pkg::ONE_STATE) && !(phaseWaitEn_reg && waitHeld_reg);

    always_ff @(posedge clk) begin
        if (rst || manualRst) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 4'h0;
            beats_reg <= 4'h0;
            phaseWaitEn_reg <= 1'b0;
            curCode_reg <= 3'h0;
            bus <= '0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (accept) begin
                        bus.area <= req.area;
                        bus.write <= req.write;
                        curCode_reg <= reqCode;
                        // only areas 6, 5 and 0 support burst
                        if (req.area == 3'h6 || req.area == 3'h5 || req.area == 3'h0) begin
                            beats_reg <= req.beats;
                        end else begin
                            beats_reg <= 4'h0;
                        end
                        if (gapNeed) begin
                            state_reg <= ST_GAP;
                            bus.idle <= 1'b1;
                            // the area being left decides the gap length
                            cnt_reg <= bwic_pkg::idle_states(idleCtrl_reg, lastArea_reg);
                            phaseWaitEn_reg <= 1'b0;
                        end else begin
                            state_reg <= ST_FIRST;
                            bus.active <= 1'b1;
                            cnt_reg <= bwic_pkg::ONE_STATE + bwic_pkg::first_waits(reqCode);
                            phaseWaitEn_reg <= (reqCode != 3'h0);
                        end
                    end
                end
                ST_GAP: begin
                    if (busRise) begin
                        if (cnt_reg == bwic_pkg::ONE_STATE) begin
                            state_reg <= ST_FIRST;
                            bus.idle <= 1'b0;
                            bus.active <= 1'b1;
                            cnt_reg <= bwic_pkg::ONE_STATE + bwic_pkg::first_waits(curCode_reg);
                            phaseWaitEn_reg <= (curCode_reg != 3'h0);
                        end else begin
                            cnt_reg <= cnt_reg - bwic_pkg::ONE_STATE;
                        end
                    end
                end
                ST_FIRST, ST_BURST: begin
                    if (phaseEnd) begin
                        if (beats_reg != 4'h0) begin
                            state_reg <= ST_BURST;
                            beats_reg <= beats_reg - 4'h1;
                            cnt_reg <= bwic_pkg::burst_pitch(curCode_reg);
                            phaseWaitEn_reg <= 1'b1;
                        end else begin
                            state_reg <= ST_IDLE;
                            bus.active <= 1'b0;
                            phaseWaitEn_reg <= 1'b0;
                        end
                    end else if (busRise && cnt_reg != bwic_pkg::ONE_STATE) begin
                        cnt_reg <= cnt_reg - bwic_pkg::ONE_STATE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // history for the turnaround decision; a manual reset forgets it
    always_ff @(posedge clk) begin
        if (rst || manualRst) begin
            lastValid_reg <= 1'b0;
            lastArea_reg <= 3'h0;
            lastRead_reg <= 1'b0;
        end else if (accept) begin
            lastValid_reg <= 1'b1;
            lastArea_reg <= req.area;
            lastRead_reg <= !req.write;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || manualRst) begin
            beatDone <= 1'b0;
            cycleDone <= 1'b0;
        end else begin
            beatDone <= (state_reg == ST_FIRST || state_reg == ST_BURST) && phaseEnd;
            cycleDone <= (state_reg == ST_FIRST || state_reg == ST_BURST) && phaseEnd && (beats_reg == 4'h0);
        end
    end

    a_idle_reset_val: assert property (@(posedge clk) rst |=> idleCtrl_reg == 16'h3ff3)
        else $error("idle control reset value wrong");

    a_wait_reset_val: assert property (@(posedge clk) rst |=> waitCtrl_reg == 16'hffff)
        else $error("wait control reset value wrong");

    a_regs_kept: assert property (@(posedge clk) disable iff (rst)
        (manualRst || standby) && !regWr |=> $stable(idleCtrl_reg) && $stable(waitCtrl_reg))
        else $error("registers changed without a write");

    a_reserved_read: assert property (@(posedge clk) disable iff (rst)
        regRd && regAddr == 4'h0 |=> regRdata[14] == 1'b0 && regRdata[3:2] == 2'b00)
        else $error("reserved bits read nonzero");

    a_gap_inserted: assert property (@(posedge clk) disable iff (rst || manualRst)
        accept && gapNeed |=> state_reg == ST_GAP && bus.idle && !bus.active)
        else $error("missing idle gap");

    a_gap_length: assert property (@(posedge clk) disable iff (rst || manualRst)
        accept && gapNeed && lastArea_reg == 3'h0 && idleCtrl_reg[1:0] == 2'b10 |=> cnt_reg == 4'h2)
        else $error("idle gap length wrong");

    a_first_waits: assert property (@(posedge clk) disable iff (rst || manualRst)
        accept && !gapNeed && req.area == 3'h4 && waitCtrl_reg[9:7] == 3'h5 |=> cnt_reg == 4'h7
        && phaseWaitEn_reg)
        else $error("first cycle wait count wrong");

    a_wait_ignored: assert property (@(posedge clk) disable iff (rst || manualRst)
        accept && !gapNeed && reqCode == 3'h0 |=> cnt_reg == 4'h1 && !phaseWaitEn_reg)
        else $error("wait not ignored for code zero");

    a_burst_pitch: assert property (@(posedge clk) disable iff (rst || manualRst)
        state_reg == ST_FIRST && phaseEnd && beats_reg != 4'h0 && curCode_reg == 3'h2
        |=> state_reg == ST_BURST && cnt_reg == 4'h3 && phaseWaitEn_reg)
        else $error("burst pitch wrong");

    a_wait_stretch: assert property (@(posedge clk) disable iff (rst || manualRst)
        (state_reg == ST_FIRST || state_reg == ST_BURST) && busRise && cnt_reg == 4'h1
        && phaseWaitEn_reg && waitHeld_reg |=> $stable(state_reg) && !beatDone)
        else $error("wait did not stretch the state");

    a_sample_edge: assert property (@(posedge clk) disable iff (rst)
        sampleSel && !pinFall[0] |=> $stable(waitHeld_reg))
        else $error("wait sampled off the falling edge");

endmodule

// ### tb/bwic_mem_model.sv
`timescale 1ns/1ps
module bwic_mem_model (
    // bus status from the controller
    input wire logic busActive,
    // commands from the bench
    input wire logic [7:0] holdStates,
    input wire logic holdLow,
    // memory side pins
    output logic busClk,
    output logic waitN
);
    logic done;
    // bus clock runs free, phase unrelated to the controller clock
    initial begin
        busClk = 1'b0;
        #3.3;
        forever #62.5 busClk = ~busClk;
    end
    // wait moves just after a rising bus edge so the falling-edge sample sees it settled
    initial begin
        waitN = 1'b1;
        done = 1'b0;
        forever begin
            @(posedge busClk);
            if (!busActive) done = 1'b0;
            if (holdLow) begin
                waitN <= 1'b0;
            end else if (busActive && holdStates > 0 && !done) begin
                done = 1'b1;
                waitN <= 1'b0;
                repeat (holdStates) @(posedge busClk);
                waitN <= 1'b1;
            end else begin
                waitN <= 1'b1;
            end
        end
    end
endmodule

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        logic [15:0] v;
        logic atLeast;
    } bwic_exp_t;
    logic clk, rst, manualRst, standby, regWr, regRd, reqValid, reqReady;
    logic busClk, waitN, beatDone, cycleDone, holdLow, rdPend, histOk, prevW;
    logic [3:0] regAddr;
    logic [7:0] holdStates;
    logic [15:0] regWdata, regRdata, idleSh, waitSh;
    logic [31:0] seed;
    bwic_pkg::bwic_req_t req;
    bwic_pkg::bwic_bus_t bus;
    bwic_exp_t q[$];
    int n_fail, num_checks, cyc, actCnt, idlCnt, prevA, nBeat;
    int wt[8] = '{0, 1, 2, 3, 4, 6, 8, 10};
    int pt[8] = '{2, 2, 3, 4, 4, 6, 8, 10};

    bwic_bus_timing bwic_bus_timing_i (.clk(clk), .rst(rst), .manualRst(manualRst), .standby(standby),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .reqValid(reqValid), .req(req), .reqReady(reqReady), .busClockIn(busClk), .waitN(waitN),
        .bus(bus), .beatDone(beatDone), .cycleDone(cycleDone));
    bwic_mem_model bwic_mem_model_i (.busActive(bus.active), .holdStates(holdStates), .holdLow(holdLow),
        .busClk(busClk), .waitN(waitN));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [31:0] xorshift(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic popChk(input logic [15:0] got);
        bwic_exp_t e;
        if (q.size() == 0) begin
            // a result with nothing expected always counts, even an unknown one
            chk(16'h0001, 16'h0000);
        end else begin
            e = q.pop_front();
            chk((e.atLeast && got >= e.v) ? e.v : got, e.v);
        end
    endtask

    // hang guard: the whole sequence needs well under this many cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 80000) begin
            n_fail++;
            $display("mismatch at %0t: timeout", $time);
            report_and_stop();
        end
    end

    // lengths are rounded to bus states of 12.5 clocks; requests start mid bus period to keep margin
    always @(posedge clk) begin
        if (rdPend) popChk(regRdata);
        rdPend = regRd && !rst;
        if (beatDone) nBeat++;
        if (bus.idle) begin
            idlCnt++;
        end else if (idlCnt > 0) begin
            popChk(16'((2 * idlCnt + 12) / 25));
            idlCnt = 0;
        end
        if (bus.active) begin
            actCnt++;
        end else if (actCnt > 0) begin
            popChk(16'((2 * actCnt + 12) / 25));
            actCnt = 0;
        end
    end

    task automatic regWrite(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        if (a == 4'h0) idleSh = d & 16'hbff3;
        if (a == 4'h4) waitSh = d;
    endtask

    task automatic regRead(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        q.push_back(bwic_exp_t'{exp, 1'b0});
        @(posedge clk);
        regRd <= 1'b0;
    endtask

    function automatic int idleOf(input int a);
        logic [1:0] f;
        f = (a == 1 || a == 7) ? 2'b00 : idleSh[2 * a +: 2];
        return (f == 2'b00) ? 1 : int'(f);
    endfunction

    function automatic int codeOf(input int a);
        case (a)
            6: return int'(waitSh[15:13]);
            5: return int'(waitSh[12:10]);
            4: return int'(waitSh[9:7]);
            3: return int'(waitSh[6:5]);
            2: return int'(waitSh[4:3]);
            0: return int'(waitSh[2:0]);
            default: return 0;
        endcase
    endfunction

    task automatic busOp(input int a, input logic w, input int b, input int atLeast);
        int c;
        int bb;
        int t;
        c = codeOf(a);
        bb = (a == 6 || a == 5 || a == 0) ? b : 0;
        if (histOk && (a != prevA || (!prevW && w))) q.push_back(bwic_exp_t'{16'(idleOf(prevA)), 1'b0});
        if (atLeast > 0) q.push_back(bwic_exp_t'{16'(atLeast), 1'b1});
        else q.push_back(bwic_exp_t'{16'(1 + wt[c] + bb * pt[c]), 1'b0});
        histOk = 1'b1;
        prevA = a;
        prevW = w;
        @(negedge busClk);
        nBeat = 0;
        @(posedge clk);
        reqValid <= 1'b1;
        req <= bwic_pkg::bwic_req_t'{3'(a), w, 4'(b)};
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (reqReady !== 1'b1 && t < 100);
        reqValid <= 1'b0;
        chk({15'h0, reqReady}, 16'h0001);
        @(posedge clk);
        chk({12'h0, bus.area, bus.write}, {12'h0, 3'(a), w});
        t = 0;
        while (cycleDone !== 1'b1 && t < 1000) begin
            @(posedge clk);
            t++;
        end
        chk({15'h0, cycleDone}, 16'h0001);
        repeat (2) @(posedge clk);
        // areas without burst must show a single transfer
        chk(16'(nBeat), 16'(bb + 1));
    endtask

    initial begin
        {rst, manualRst, standby, regWr, regRd, reqValid, holdLow} = 7'h40;
        {regAddr, regWdata, req, holdStates} = '0;
        {n_fail, num_checks, cyc, actCnt, idlCnt, prevA, nBeat} = '0;
        {rdPend, histOk, prevW} = 3'h0;
        seed = 32'h2541f520;
        idleSh = 16'h3ff3;
        waitSh = 16'hffff;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        regRead(4'h0, 16'h3ff3);
        regRead(4'h4, 16'hffff);
        regRead(4'h8, 16'h0000);
        // software keeps the reserved bits at zero
        regWrite(4'h0, 16'hbff3);
        regWrite(4'h8, 16'h1234);
        regRead(4'h0, 16'hbff3);
        for (int k = 0; k < 4; k++) begin
            seed = xorshift(seed);
            regWrite(4'h4, seed[15:0]);
            regRead(4'h4, waitSh);
        end
        $display("registers test done");
        @(posedge clk);
        manualRst <= 1'b1;
        standby <= 1'b1;
        repeat (2) @(posedge clk);
        chk({15'h0, reqReady}, 16'h0000);
        manualRst <= 1'b0;
        standby <= 1'b0;
        histOk = 1'b0;
        regRead(4'h0, idleSh);
        regRead(4'h4, waitSh);
        $display("manual reset test done");
        // wait sampling select set before memory ever asserts wait
        // area 0 gets a two-state gap so the gap length check is reached
        regWrite(4'h0, 16'h86e2);
        for (int c = 0; c < 8; c++) begin
            regWrite(4'h4, {3'(c), 3'(c), 3'(c), 2'(c), 2'(c), 3'(c)});
            foreach (wt[k]) busOp((k == 5) ? 3 : (32'h12304567 >> (4 * k)) & 7, k % 2, k % 3, 0);
        end
        $display("timing test done");
        regWrite(4'h4, 16'h0080);
        holdStates = 8'h05;
        busOp(4, 1'b0, 0, 5);
        holdStates = 8'h00;
        holdLow = 1'b1;
        regWrite(4'h4, 16'h0000);
        busOp(4, 1'b0, 0, 0);
        holdLow = 1'b0;
        // let wait go high again before a code that honours it
        repeat (2) @(posedge busClk);
        regWrite(4'h4, 16'h0280);
        busOp(4, 1'b0, 0, 0);
        $display("wait test done");
        for (int k = 0; k < 24; k++) begin
            seed = xorshift(seed);
            if (k % 6 == 0) regWrite(4'h4, seed[15:0]);
            busOp(int'(seed[18:16]), seed[19], int'(seed[21:20]), 0);
        end
        $display("random test done");
        chk(16'(q.size()), 16'h0000);
        report_and_stop();
    end
endmodule
